// [seq_regs.vh]
/*
 Constants of the machine cycle sequencer: register offsets, reset values, field bits, timing, opcodes.
 Included by the sequencer; holds definitions only.
*/
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH
// Register byte addresses on the register bus
`define REG_SW_OFF       8'hd0
`define REG_ARITH_OFF    8'he0
`define REG_AUX_OFF      8'hf0
`define REG_CTRL_OFF     8'h00
`define REG_STAT_OFF     8'h04
`define REG_PC_OFF       8'h08
`define REG_IR_OFF       8'h0c
// Reset values
`define SW_RST           8'h00
`define ARITH_RST        8'h00
`define AUX_RST          8'h00
`define PC_RST           16'h0000
// Carry bit position in the status word
`define SW_CY_BIT        7
// Control register fields
`define CTRL_RUN_BIT     0
// Timing: oscillator periods per state and states per machine cycle
`define OSC_PER_STATE    2
`define STATES_PER_CYC   6
// Opcodes decoded by the sequencer
`define OP_XMOVE_RD      8'he0
`define OP_XMOVE_WR      8'hf0
`define OP_BR_ZERO       8'h60
`define OP_BR_NONZERO    8'h70
`define OP_DECBR_DIR     8'hd5
`define OP_DECBR_REG     5'h1b
`define OP_CMPBR_IMM     8'hb4
`define OP_SJMP          8'h80
`define OP_NOP           8'h00
`endif

// [cpu_machine_cycle_sequencer.v]
/*
 Machine cycle sequencer of a 12-clock core: states, phases, code fetches,
 two-cycle external data move and relative branches, with an APB register slave.
 Assumes program and data memory answer within one oscillator period on the
 internal bus, and an APB master synchronous to clock.
*/
// Our own choice: register access over APB.
// Function
// - Each machine cycle walks states one to six before the next begins.
// - Every state lasts two oscillator periods; a machine cycle is twelve.
// - Each state has a first phase and a second phase, one period each.
// - Two code fetches are issued in every machine cycle except the second cycle of an external data move.
// - An unneeded fetched byte is dropped and the program counter holds.
// - The opcode is latched into the instruction register in state one.
// - The second code fetch happens in state four.
// - A one-cycle instruction completes at the end of state six.
// - External data moves take exactly two machine cycles.
// - No code fetch in the second cycle of an external data move.
// - Decrement-and-branch decrements its byte and branches only if nonzero.
// - Reads of unoccupied register addresses return undefined data (zero here).
// - Writes to unoccupied register addresses change nothing.
// - Memory is reached over 16-bit address, 8-bit data, strobes and reset.
// - A taken branch adds a signed 8-bit offset to the program counter.
// - Zero-test branches look at the accumulator directly.
// - Compare-and-branch compares unsigned and sets carry when first is less.
`timescale 1ns/1ns
`include "seq_regs.vh"
module cpu_machine_cycle_sequencer (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Internal memory bus
    output reg  [15:0] mem_addr,
    output reg  [7:0]  mem_wdata,
    input  wire [7:0]  mem_rdata,
    output reg         mem_rd_n,
    output reg         mem_wr_n,
    output reg         program_fetch_strobe_n,
    output reg         addr_latch,
    output reg         mem_reset_n,
    // Sequencer status
    output reg  [2:0]  state_num,
    output reg         phase2
);

    // Operating modes of a machine cycle, one-hot
    localparam ST_FETCH  = 3'b001;
    localparam ST_XMOVE2 = 3'b010;
    localparam ST_BYTE2  = 3'b100;

    // Machine cycle states, one-hot, first state in bit 0
    localparam ST_ONE    = 6'h01;

    // Reset release
    reg         rst_s1_r;
    reg         rst_s2_r;
    wire        rst_n;

    // Timing
    reg  [5:0]  st_r;
    reg         ph_r;
    reg  [2:0]  mode_r;
    reg  [31:0] mcyc_r;

    // Execution state
    reg  [15:0] pc_r;
    reg  [15:0] dptr_r;
    reg  [7:0]  ir_r;
    reg  [7:0]  opnd_r;
    reg  [7:0]  cnt_r;
    reg  [7:0]  sw_r;
    reg  [7:0]  arith_r;
    reg  [7:0]  aux_r;
    reg         run_r;

    // Decode
    wire        is_xmove;
    wire        is_decbr;
    wire        is_two;
    wire [15:0] rel;
    reg         take;

    // Slot strobes
    wire        ph1_tick;
    wire        ph2_tick;
    wire        cyc_end;
    wire        xmove_cyc;
    wire        fetch_slot;
    wire        op_slot;
    wire        byte_slot;
    wire        branch_slot;
    wire        xmove_latch;
    wire        xmove_strobe;
    wire        xmove_load;

    // Register bus decode
    wire        wr_acc;
    wire        rd_acc;

    assign rst_n = rst_s2_r;

    // Instruction classes
    assign is_xmove = (ir_r == `OP_XMOVE_RD) ||
                      (ir_r == `OP_XMOVE_WR);
    assign is_decbr = (ir_r == `OP_DECBR_DIR) ||
                      (ir_r[7:3] == `OP_DECBR_REG);
    assign is_two   = (ir_r == `OP_BR_ZERO) ||
                      (ir_r == `OP_BR_NONZERO) ||
                      (ir_r == `OP_SJMP) ||
                      (ir_r == `OP_CMPBR_IMM) ||
                      is_decbr;
    assign rel      = {{8{opnd_r[7]}}, opnd_r};

    // Slots within the machine cycle
    assign ph1_tick     = run_r && !ph_r;
    assign ph2_tick     = run_r && ph_r;
    assign cyc_end      = ph2_tick && st_r[5];
    assign xmove_cyc    = (mode_r == ST_XMOVE2);
    assign fetch_slot   = ph1_tick && (st_r[0] || st_r[3]) && !xmove_cyc;
    assign op_slot      = ph2_tick && st_r[0] && (mode_r == ST_FETCH);
    assign byte_slot    = ph2_tick && st_r[3] && (mode_r == ST_FETCH) && is_two;
    assign branch_slot  = ph2_tick && st_r[4] && (mode_r == ST_BYTE2);
    assign xmove_latch  = ph1_tick && st_r[1] && xmove_cyc;
    assign xmove_strobe = run_r && (st_r[2] || st_r[3]) && xmove_cyc;
    assign xmove_load   = ph2_tick && st_r[3] && xmove_cyc &&
                          (ir_r == `OP_XMOVE_RD);

    // Register bus strobes
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;

    // Branch decision on the offset byte
    always @* begin
        take = 1'b0;
        case (ir_r)
            `OP_BR_ZERO: begin
                take = (arith_r == 8'h00);
            end
            `OP_BR_NONZERO: begin
                take = (arith_r != 8'h00);
            end
            `OP_SJMP: begin
                take = 1'b1;
            end
            `OP_CMPBR_IMM: begin
                take = (arith_r != aux_r);
            end
            default: begin
                // Counter was already decremented in the first cycle
                take = is_decbr && (cnt_r != 8'h00);
            end
        endcase
    end

    // Reset release through two flip-flops
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Register bus answer: ready one cycle after setup, read data taken at setup
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (rd_acc) begin
                case (paddr)
                    `REG_SW_OFF:    prdata <= {24'h0, sw_r};
                    `REG_ARITH_OFF: prdata <= {24'h0, arith_r};
                    `REG_AUX_OFF:   prdata <= {24'h0, aux_r};
                    `REG_CTRL_OFF:  prdata <= {31'h0, run_r};
                    `REG_STAT_OFF:  prdata <= mcyc_r;
                    `REG_PC_OFF:    prdata <= {16'h0, pc_r};
                    `REG_IR_OFF:    prdata <= {24'h0, ir_r};
                    default:        prdata <= 32'h0;
                endcase
            end
        end
    end

    // Phase and state sequencing
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= ST_ONE;
            ph_r      <= 1'b0;
            phase2    <= 1'b0;
            state_num <= 3'h1;
        end else if (run_r) begin
            ph_r   <= ~ph_r;
            phase2 <= ~ph_r;
            if (ph_r) begin
                st_r <= {st_r[4:0], st_r[5]};
                // State number follows the one-hot state
                if (st_r[5]) begin
                    state_num <= 3'h1;
                end else begin
                    state_num <= state_num + 3'h1;
                end
            end
        end
    end

    // Machine cycle mode and count
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= ST_FETCH;
            mcyc_r <= 32'h0;
        end else if (cyc_end) begin
            mcyc_r <= mcyc_r + 32'h1;
            case (mode_r)
                ST_XMOVE2: begin
                    mode_r <= ST_FETCH;
                end
                ST_BYTE2: begin
                    mode_r <= ST_FETCH;
                end
                ST_FETCH: begin
                    if (is_xmove) begin
                        mode_r <= ST_XMOVE2;
                    end else if (is_two) begin
                        mode_r <= ST_BYTE2;
                    end else begin
                        mode_r <= ST_FETCH;
                    end
                end
                default: begin
                    mode_r <= ST_FETCH;
                end
            endcase
        end
    end

    // Registers, instruction register and program counter
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_r    <= `PC_RST;
            dptr_r  <= 16'h0000;
            ir_r    <= `OP_NOP;
            opnd_r  <= 8'h00;
            cnt_r   <= 8'h00;
            sw_r    <= `SW_RST;
            arith_r <= `ARITH_RST;
            aux_r   <= `AUX_RST;
            run_r   <= 1'b0;
        end else begin
            // Writes land at the access edge
            if (wr_acc && pready) begin
                case (paddr)
                    `REG_SW_OFF:    sw_r    <= pwdata[7:0];
                    `REG_ARITH_OFF: arith_r <= pwdata[7:0];
                    `REG_AUX_OFF:   aux_r   <= pwdata[7:0];
                    `REG_CTRL_OFF:  run_r   <= pwdata[`CTRL_RUN_BIT];
                    `REG_PC_OFF:    dptr_r  <= pwdata[15:0];
                    default:        ;
                endcase
            end
            // Opcode in state one
            if (op_slot) begin
                ir_r <= mem_rdata;
                pc_r <= pc_r + 16'h1;
            end
            // Second byte in state four
            if (byte_slot) begin
                opnd_r <= mem_rdata;
                pc_r   <= pc_r + 16'h1;
                if (is_decbr) begin
                    cnt_r <= cnt_r - 8'h01;
                end
                if (ir_r == `OP_CMPBR_IMM) begin
                    sw_r[`SW_CY_BIT] <= (arith_r < aux_r);
                end
            end
            // A byte that no instruction needs is dropped, program counter holds
            // Branch resolves in state five of the second cycle
            if (branch_slot) begin
                if (take) begin
                    pc_r <= pc_r + rel;
                end
                // A false condition leaves the program counter after the branch
            end
            // Data move read lands in the accumulator
            if (xmove_load) begin
                arith_r <= mem_rdata;
            end
        end
    end

    // Memory bus strobes and address
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr               <= 16'h0000;
            mem_wdata              <= 8'h00;
            mem_rd_n               <= 1'b1;
            mem_wr_n               <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            addr_latch             <= 1'b0;
            mem_reset_n            <= 1'b0;
        end else begin
            mem_reset_n            <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            mem_rd_n               <= 1'b1;
            mem_wr_n               <= 1'b1;
            addr_latch             <= 1'b0;
            // Code fetch in states one and four, none in data move cycle two
            if (fetch_slot) begin
                mem_addr               <= pc_r;
                addr_latch             <= 1'b1;
                program_fetch_strobe_n <= 1'b0;
            end
            // Data address latched in state two of cycle two
            if (xmove_latch) begin
                mem_addr   <= dptr_r;
                addr_latch <= 1'b1;
            end
            // Data strobe over states three and four
            if (xmove_strobe) begin
                mem_addr  <= dptr_r;
                mem_wdata <= arith_r;
                mem_rd_n  <= (ir_r != `OP_XMOVE_RD);
                mem_wr_n  <= (ir_r != `OP_XMOVE_WR);
            end
        end
    end

endmodule // cpu_machine_cycle_sequencer

// [seq_props.sv]
/* Port checker of the machine cycle sequencer.
 Bound to cpu_machine_cycle_sequencer; one clock domain. */
`timescale 1ns/1ns
module seq_props (
    // Clock and reset
    input wire       clock,
    input wire       rstn,
    // APB
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    // Memory bus
    input wire       mem_rd_n,
    input wire       mem_wr_n,
    input wire       program_fetch_strobe_n,
    input wire       addr_latch,
    // Sequencer status
    input wire [2:0] state_num,
    input wire       phase2
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire fetch = !program_fetch_strobe_n;
    a_state_range: assert property (state_num >= 1 && state_num <= 6)
        else $error("state number out of range");
    a_state_next: assert property ($fell(phase2) |->
        state_num == ($past(state_num) % 6) + 1) else $error("state order broken");
    a_state_hold: assert property ($changed(state_num) |=> $stable(state_num))
        else $error("state shorter than two periods");
    a_phase_one: assert property (phase2 |=> !phase2)
        else $error("second phase longer than one period");
    a_phase_pair: assert property ($rose(phase2) |-> $stable(state_num))
        else $error("state changed inside a state");
    a_fetch_slot: assert property (fetch |-> phase2 && (state_num == 1 || state_num == 4))
        else $error("fetch outside states one and four");
    a_fetch_latch: assert property (fetch |-> addr_latch)
        else $error("fetch without address latch");
    a_fetch_once: assert property (fetch |=> !fetch)
        else $error("fetch strobe longer than one period");
    a_strobe_excl: assert property (!(fetch && (!mem_rd_n || !mem_wr_n)))
        else $error("fetch during data move");
    a_apb_ready: assert property (psel && !penable |=> pready && !pslverr)
        else $error("no ready after setup");
endmodule // seq_props
bind cpu_machine_cycle_sequencer seq_props u_props (.clock(clock), .rstn(rstn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .addr_latch(addr_latch),
    .program_fetch_strobe_n(program_fetch_strobe_n), .state_num(state_num),
    .phase2(phase2));

// [mem_model.sv]
/* Program and data memory on the internal bus.
 Assumes byte strobes from the sequencer; answers at once. */
`timescale 1ns/1ns
module mem_model (
    // Clock
    input  wire        clock,
    // Internal memory bus
    input  wire [15:0] mem_addr,
    input  wire [7:0]  mem_wdata,
    output reg  [7:0]  mem_rdata,
    input  wire        mem_rd_n,
    input  wire        mem_wr_n,
    input  wire        program_fetch_strobe_n,
    input  wire        mem_reset_n
);
    reg [7:0] code [0:255];
    reg [7:0] data [0:255];
    reg [7:0] last = 8'h00;
    // Read answers; idle bus shows the inverse of the last byte
    always @* begin
        if (!program_fetch_strobe_n) mem_rdata = code[mem_addr[7:0]];
        else if (!mem_rd_n) mem_rdata = data[mem_addr[7:0]];
        else mem_rdata = ~last;
    end
    always @(posedge clock) begin
        if (!program_fetch_strobe_n || !mem_rd_n) last <= mem_rdata;
        if (!mem_wr_n && mem_reset_n) data[mem_addr[7:0]] <= mem_wdata;
    end
endmodule // mem_model

// [tb_top.sv]
/* Self-checking bench of the sequencer with its memory model.
 Assumes APB answers with one access cycle. */
`timescale 1ns/1ns
`include "seq_regs.vh"
module tb_top;
    reg         clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 8'h00, v, dbyte;
    reg  [31:0] pwdata = 32'h0, seed = 32'ha7b8, rd_q[$];
    reg  [15:0] fetch_q[$];
    wire [31:0] prdata;
    wire [15:0] mem_addr;
    wire [7:0]  mem_wdata, mem_rdata;
    wire [2:0]  state_num;
    wire        pready, pslverr, mem_rd_n, mem_wr_n, program_fetch_strobe_n;
    wire        addr_latch, mem_reset_n, phase2;
    integer     fail_count = 0, num_checks = 0, i;
    cpu_machine_cycle_sequencer DUT (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rd_n(mem_rd_n),
        .mem_wr_n(mem_wr_n), .program_fetch_strobe_n(program_fetch_strobe_n),
        .addr_latch(addr_latch), .mem_reset_n(mem_reset_n),
        .state_num(state_num), .phase2(phase2));
    mem_model mem (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
        .program_fetch_strobe_n(program_fetch_strobe_n), .mem_reset_n(mem_reset_n));
    initial forever #5 clock = ~clock;
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task cmp_read(input [31:0] e);
        num_checks = num_checks + 1;
        if (prdata !== e) begin
            $display("Error prdata expected %h seen %h", e, prdata);
            fail_count = fail_count + 1;
        end
    endtask
    task cmp_fetch(input [15:0] e);
        num_checks = num_checks + 1;
        if (mem_addr !== e) begin
            $display("Error fetch address expected %h seen %h", e, mem_addr);
            fail_count = fail_count + 1;
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock iff pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Result watcher: oldest note against each answer
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && rd_q.size() > 0)
            cmp_read(rd_q.pop_front());
        if (!program_fetch_strobe_n && addr_latch && fetch_q.size() > 0)
            cmp_fetch(fetch_q.pop_front());
    end
    initial begin
        #20000;
        fail_count = fail_count + 1;
        close_out;
    end
    initial begin
        for (i = 0; i < 256; i = i + 1) begin
            mem.code[i] = `OP_NOP;
            mem.data[i] = 8'h00;
        end
        mem.code[2] = `OP_XMOVE_RD;
        mem.code[3] = `OP_DECBR_DIR;
        mem.code[4] = 8'h10;
        seed = xs(seed);
        dbyte = seed[7:0];
        mem.data[8'h5a] = dbyte;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`REG_SW_OFF, {24'h0, `SW_RST});
        rd(`REG_ARITH_OFF, {24'h0, `ARITH_RST});
        rd(`REG_AUX_OFF, {24'h0, `AUX_RST});
        for (i = 0; i < 3; i = i + 1) begin
            seed = xs(seed);
            v = seed[7:0];
            apb(1'b1, 8'hd0 + 8'(i << 4), {24'h0, v});
            rd(8'hd0 + 8'(i << 4), {24'h0, v});
        end
        apb(1'b1, 8'h30, 32'h0);
        rd(8'h30, 32'h0);
        rd(`REG_AUX_OFF, {24'h0, v});
        apb(1'b1, `REG_PC_OFF, 32'h5a);
        fetch_q = '{16'h0, 16'h1, 16'h1, 16'h2, 16'h2, 16'h3, 16'h3, 16'h4,
                    16'h5, 16'h5, 16'h15, 16'h16};
        apb(1'b1, `REG_CTRL_OFF, 32'h1);
        repeat (100) @(posedge clock);
        rd(`REG_ARITH_OFF, {24'h0, dbyte});
        num_checks = num_checks + 1;
        if (fetch_q.size() != 0) begin
            $display("Error fetches expected 0 left seen %0d", fetch_q.size());
            fail_count = fail_count + 1;
        end
        close_out;
    end
endmodule // tb_top
